/* File: src/pim_image_mapper.v */
// Process image mapper: analog words ahead of digital bytes, fault flags in input image
`include "pim_consts.vh"
`default_nettype none
module pim_image_mapper (
   input  wire        clk,
   input  wire        nrst,
   input  wire [2:0]  inAddr,
   output reg  [15:0] inData,
   input  wire        outWrEn,
   input  wire [2:0]  outAddr,
   input  wire [1:0]  outByteEn,
   input  wire [15:0] outWrData,
   output reg  [15:0] outRdData,
   input  wire [63:0] anaInValue,
   input  wire [31:0] anaInStatus,
   input  wire [7:0]  overloadPin,
   input  wire [7:0]  shortPin,
   input  wire [7:0]  openWirePin,
   output wire [63:0] anaOutValue,
   output wire [7:0]  switchDrive
);
   reg  [15:0] anaIn_r [0:3];
   reg  [15:0] anaOut_r [0:3];
   reg  [7:0]  drive_r;
   wire [7:0]  faultFlags;
   wire [63:0] anaInSync;
   reg  [15:0] inData_nxt;
   reg  [15:0] outRdData_nxt;

   pim_fault_image uFault (
      .clk          (clk),
      .nrst         (nrst),
      .overloadPin  (overloadPin),
      .shortPin     (shortPin),
      .openWirePin  (openWirePin),
      .faultFlags_r (faultFlags)
   );

   pim_sync2 #(.W(64)) uAnaSync (.clk(clk), .nrst(nrst), .din(anaInValue), .dout(anaInSync));

   genvar k;
   generate
      for (k = 0; k < `PIM_ANA_CH; k = k + 1) begin : gAna
         // Word index of this channel, at the width of the address port
         localparam [2:0] CH_OFS = k;
         // Status byte of each channel is deliberately not captured
         always @(posedge clk) begin
            if (!nrst)
               anaIn_r[k] <= 16'h0000;
            else
               anaIn_r[k] <= anaInSync[16*k +: 16];
         end
         always @(posedge clk) begin
            if (!nrst) begin
               anaOut_r[k] <= `PIM_AOUT_RST;
            end else if (outWrEn && outAddr == CH_OFS) begin
               if (outByteEn[0])
                  anaOut_r[k][7:0] <= outWrData[7:0];
               if (outByteEn[1])
                  anaOut_r[k][15:8] <= outWrData[15:8];
            end
         end
         assign anaOutValue[16*k +: 16] = anaOut_r[k];
      end
   endgenerate

   always @(posedge clk) begin
      if (!nrst)
         drive_r <= `PIM_DRIVE_RST;
      else if (outWrEn && outAddr == `PIM_DIG_OFS && outByteEn[0])
         drive_r <= outWrData[7:0];
   end
   assign switchDrive = drive_r;

   always @* begin
      inData_nxt = 16'h0000;
      if (inAddr < `PIM_DIG_OFS)
         inData_nxt = anaIn_r[inAddr[1:0]];
      else if (inAddr == `PIM_DIG_OFS)
         inData_nxt = {8'h00, faultFlags};
   end

   always @* begin
      outRdData_nxt = 16'h0000;
      if (outAddr < `PIM_DIG_OFS)
         outRdData_nxt = anaOut_r[outAddr[1:0]];
      else if (outAddr == `PIM_DIG_OFS)
         outRdData_nxt = {8'h00, drive_r};
   end

   always @(posedge clk) begin
      if (!nrst) begin
         inData    <= 16'h0000;
         outRdData <= 16'h0000;
      end else begin
         inData    <= inData_nxt;
         outRdData <= outRdData_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: src/pim_consts.vh */
// Constants for the process image mapper
`ifndef PIM_CONSTS_VH
`define PIM_CONSTS_VH
`define PIM_AIN_CH1_OFS     3'h0
`define PIM_AIN_CH2_OFS     3'h1
`define PIM_AIN_CH3_OFS     3'h2
`define PIM_AIN_CH4_OFS     3'h3
`define PIM_AOUT_CH1_OFS    3'h0
`define PIM_AOUT_CH2_OFS    3'h1
`define PIM_AOUT_CH3_OFS    3'h2
`define PIM_AOUT_CH4_OFS    3'h3
`define PIM_DIG_OFS         3'h4
`define PIM_ANA_CH          4
`define PIM_DIG_CH          8
`define PIM_WORD_W          16
`define PIM_BYTE_W          8
`define PIM_STAT_W          8
`define PIM_AOUT_RST        16'h0000
`define PIM_DRIVE_RST       8'h00
`define PIM_FAULT_RST       8'h00
`endif

/* File: src/pim_sync2.v */
// Two-stage synchroniser for a vector of pin inputs
`default_nettype none
module pim_sync2 #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta_r;
   always @(posedge clk) begin
      if (!nrst) begin
         meta_r <= {W{1'b0}};
         dout   <= {W{1'b0}};
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: src/pim_fault_image.v */
// Fault flag image for the eight-channel switched-output module
`include "pim_consts.vh"
`default_nettype none
module pim_fault_image (
   input  wire       clk,
   input  wire       nrst,
   input  wire [7:0] overloadPin,
   input  wire [7:0] shortPin,
   input  wire [7:0] openWirePin,
   output reg  [7:0] faultFlags_r
);
   wire [7:0] ovl;
   wire [7:0] sht;
   wire [7:0] opn;
   pim_sync2 #(.W(8)) uOvl (.clk(clk), .nrst(nrst), .din(overloadPin), .dout(ovl));
   pim_sync2 #(.W(8)) uSht (.clk(clk), .nrst(nrst), .din(shortPin), .dout(sht));
   pim_sync2 #(.W(8)) uOpn (.clk(clk), .nrst(nrst), .din(openWirePin), .dout(opn));
   genvar i;
   generate
      for (i = 0; i < `PIM_DIG_CH; i = i + 1) begin : gFlag
         always @(posedge clk) begin
            if (!nrst)
               faultFlags_r[i] <= 1'b0;
            else
               faultFlags_r[i] <= ovl[i] | sht[i] | opn[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* File: verif/pim_props.sv */
// Port checker for the image mapper
`default_nettype none
module pim_props(
   input wire logic        clk, nrst, outWrEn,
   input wire logic [2:0]  inAddr, outAddr,
   input wire logic [1:0]  outByteEn,
   input wire logic [15:0] inData, outWrData, outRdData,
   input wire logic [63:0] anaInValue, anaOutValue,
   input wire logic [7:0]  overloadPin, shortPin, openWirePin, switchDrive);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic [7:0] f = overloadPin | shortPin | openWirePin;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_drv_wr: assert property (outWrEn && outAddr == 3'h4 && outByteEn[0] |=>
      switchDrive == $past(outWrData[7:0])) else $error("drive");
   a_aout_wr: assert property (outWrEn && outAddr == 3'h1 && &outByteEn |=>
      anaOutValue[31:16] == $past(outWrData)) else $error("aout");
   a_aout_rb: assert property (outAddr == 3'h2 && !outWrEn |=>
      outRdData == anaOutValue[47:32]) else $error("aout rb");
   a_drv_rb: assert property (outAddr == 3'h4 && !outWrEn |=>
      outRdData[7:0] == switchDrive) else $error("drive rb");
   a_bad_wr: assert property (outWrEn && outAddr > 3'h4 |=>
      $stable(anaOutValue) && $stable(switchDrive)) else $error("bad wr");
   a_null_rd: assert property (inAddr > 3'h4 |=> inData == 16'h0000) else $error("null rd");
   a_ain_rd: assert property ($stable(anaInValue)[*4] ##0 inAddr == 3'h2 |=>
      inData == $past(anaInValue[47:32])) else $error("ain");
   a_flt_rd: assert property ($stable(f)[*5] ##0 inAddr == 3'h4 |=>
      inData == {8'h00, $past(f)}) else $error("fault");
   cover property (outWrEn && outAddr == 3'h4);
   cover property (inAddr == 3'h4 && f != 8'h00);
   cover property (outWrEn && outAddr > 3'h4);
endmodule
bind pim_image_mapper pim_props i_pim_props(.*);
`default_nettype wire

/* File: verif/pim_coupler.sv */
// Coupler model on the image ports
`default_nettype none
module pim_coupler(
   input wire logic        clk,
   input wire logic [15:0] inData, outRdData,
   output var logic        outWrEn = 0,
   output var logic [2:0]  inAddr = 0, outAddr = 0,
   output var logic [1:0]  outByteEn = 0,
   output var logic [15:0] outWrData = 0);
   timeunit 1ns;
   timeprecision 100ps;
   task wr(logic [2:0] a, logic [1:0] b, logic [15:0] d);
      @(negedge clk) {outWrEn, outAddr, outByteEn, outWrData} = {1'b1, a, b, d};
      @(negedge clk) {outWrEn, outWrData} = {1'b0, ~d};
   endtask
   task rd(logic [2:0] a, output logic [15:0] qi, qo);
      @(negedge clk) {inAddr, outAddr} = {a, a};
      @(negedge clk) {qi, qo} = {inData, outRdData};
   endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Random bench for the image mapper
`default_nettype none
module testbench;
   timeunit 1ns / 100ps;
   logic        clk = 0, nrst = 0, outWrEn;
   logic [2:0]  inAddr, outAddr;
   logic [1:0]  outByteEn;
   logic [15:0] inData, outWrData, outRdData, qi, qo, w;
   logic [63:0] anaInValue = 0, anaOutValue;
   logic [31:0] anaInStatus = 0;
   logic [7:0]  overloadPin = 0, shortPin = 0, openWirePin = 0, switchDrive, d;
   int          error_cnt, total_checks;
   pim_coupler i_pim_coupler(.*);
   pim_image_mapper i_pim_image_mapper(.*);
   function logic [15:0] wd(logic [63:0] v, int k); return v[16*k+:16]; endfunction
   task chk(string n, logic [15:0] e, g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task finish_test;
      $display("checks %0d bad %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial forever #2.5 clk = ~clk;
   initial begin
      #5000;
      error_cnt++;
      finish_test;
   end
   initial begin
      w = $urandom(32'hf3ed129f);
      repeat (12) @(negedge clk);
      nrst = 1;
      for (int k = 0; k < 4; k++) begin
         w = $urandom;
         i_pim_coupler.wr(k, 3, w);
         i_pim_coupler.rd(k, qi, qo);
         chk("aout", w, wd(anaOutValue, k));
         chk("aout rb", w, qo);
      end
      d = $urandom | 8'h81;
      {anaInValue, anaInStatus} = {$urandom, $urandom, $urandom};
      i_pim_coupler.wr(4, 1, d);
      i_pim_coupler.wr(4, 2, 0);
      i_pim_coupler.wr(7, 3, 0);
      chk("drive", d, switchDrive);
      $display("test out done");
      for (int p = 0; p < 4; p++) begin
         {overloadPin, shortPin, openWirePin} = {d, 16'h0000} >> 8 * p;
         repeat (5) @(negedge clk);
         i_pim_coupler.rd(4, qi, qo);
         chk("fault", p < 3 ? d : 0, qi);
         chk("drive rb", d, qo);
      end
      $display("test fault done");
      for (int k = 0; k < 6; k++) begin
         i_pim_coupler.rd(k, qi, qo);
         if (k != 4) chk("ain", k < 4 ? wd(anaInValue, k) : 0, qi);
      end
      $display("test ain done");
      finish_test;
   end
endmodule
`default_nettype wire
